/* File: core/arch_register_file_flags.sv */
// Architectural general registers, instruction pointer and flags word
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ps
module arch_register_file_flags #(
    parameter int GPR_COUNT = 8
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire arch_regs_pkg::gpr_write_type gpr_wr_i,
    input wire logic [2:0] gpr_rd_index_i,
    input wire arch_regs_pkg::gpr_view_type gpr_rd_view_i,
    input wire logic addr_calc_i,
    input wire logic ip_load_i,
    input wire logic [31:0] ip_value_i,
    input wire arch_regs_pkg::flags_op_type flags_op_i,
    input wire logic [31:0] flags_image_i,
    input wire logic [1:0] current_privilege_i,
    input wire logic protected_mode_i,
    input wire logic flags_store_i,
    input wire arch_regs_pkg::mem_ref_type mem_ref_i,
    input wire logic io_instr_i,
    input wire logic privileged_opcode_i,
    input wire logic sys_reg_access_i,
    input wire logic debug_fault_i,
    input wire logic maskable_irq_i,
    input wire logic interrupt_return_instr_i,
    output logic [31:0] reg_rdata_o,
    output logic [31:0] gpr_rdata_o,
    output logic [31:0] flags_store_image_o,
    output arch_regs_pkg::fault_type fault_o,
    output logic io_bitmap_check_o,
    output logic debug_fault_taken_o,
    output logic irq_accept_o,
    output logic inter_task_return_o,
    output logic sys_reg_grant_o,
    output logic legacy_emulation_o
);

    // ****************************************
    // Functions
    // ****************************************
    // Merge a write into a register according to its operand view
    function automatic logic [31:0] merge_view(input logic [31:0] old,
                                               input arch_regs_pkg::gpr_view_type view,
                                               input logic [31:0] data,
                                               input logic byte_ok);
        logic [31:0] res;
        res = old;
        case (view)
            arch_regs_pkg::VIEW_DWORD: res = data;
            arch_regs_pkg::VIEW_WORD: res[15:0] = data[15:0];
            arch_regs_pkg::VIEW_LOW_BYTE: if (byte_ok) res[7:0] = data[7:0];
            default: if (byte_ok) res[15:8] = data[7:0];
        endcase
        return res;
    endfunction

    function automatic logic [31:0] read_view(input logic [31:0] val,
                                              input arch_regs_pkg::gpr_view_type view);
        logic [31:0] res;
        res = 32'h0000_0000;
        case (view)
            arch_regs_pkg::VIEW_DWORD: res = val;
            arch_regs_pkg::VIEW_WORD: res[15:0] = val[15:0];
            arch_regs_pkg::VIEW_LOW_BYTE: res[7:0] = val[7:0];
            default: res[7:0] = val[15:8];
        endcase
        return res;
    endfunction

    // ****************************************
    // State
    // ****************************************
    logic [31:0] gpr_q [GPR_COUNT];
    logic [31:0] next_instr_pointer_q;
    logic [31:0] status_control_word_q;
    logic [31:0] status_control_word_d;

    wire logic [31:0] flags_w = status_control_word_q;
    wire logic [1:0] io_privilege_ceiling = flags_w[arch_regs_pkg::IO_PRIVILEGE_CEILING_LO +: 2];
    wire logic alignment_check_enable = flags_w[arch_regs_pkg::AC_BIT];
    wire logic legacy_emulation_enable = flags_w[arch_regs_pkg::VM_BIT];
    wire logic resume_flag = flags_w[arch_regs_pkg::RF_BIT];
    wire logic nested_task_flag = flags_w[arch_regs_pkg::NT_BIT];
    wire logic priv_kernel = current_privilege_i == arch_regs_pkg::PRIV_KERNEL;
    wire logic within_ceiling = current_privilege_i <= io_privilege_ceiling;

    // ****************************************
    // Register bus decode
    // ****************************************
    wire logic bus_gpr_hit = reg_addr_i <= arch_regs_pkg::GPR_LAST_OFS;
    wire logic [2:0] bus_gpr_idx = reg_addr_i[4:2];
    wire logic bus_flags_wr = reg_wr_i && reg_addr_i == arch_regs_pkg::FLAGS_OFS;
    wire logic bus_short_flags_wr = reg_wr_i && reg_addr_i == arch_regs_pkg::SHORT_FLAGS_OFS;
    wire logic [31:0] status_word = {27'h0, legacy_emulation_enable, resume_flag,
                                     nested_task_flag, io_privilege_ceiling};
    logic [31:0] bus_rdata;
    always_comb begin
        if (bus_gpr_hit) begin
            bus_rdata = gpr_q[bus_gpr_idx];
        end else if (reg_addr_i == arch_regs_pkg::NEXT_IP_OFS) begin
            bus_rdata = next_instr_pointer_q;
        end else if (reg_addr_i == arch_regs_pkg::SHORT_IP_OFS) begin
            bus_rdata = {16'h0, next_instr_pointer_q[15:0]};
        end else if (reg_addr_i == arch_regs_pkg::FLAGS_OFS) begin
            bus_rdata = flags_w;
        end else if (reg_addr_i == arch_regs_pkg::SHORT_FLAGS_OFS) begin
            bus_rdata = {16'h0, flags_w[15:0]};
        end else if (reg_addr_i == arch_regs_pkg::STATUS_OFS) begin
            bus_rdata = status_word;
        end else begin
            bus_rdata = 32'h0000_0000;
        end
    end

    // ****************************************
    // Flags next value
    // ****************************************
    // Fields each op may change; the rest of the image is ignored
    logic [31:0] load_mask;
    always_comb begin
        load_mask = ~(arch_regs_pkg::FLAGS_ZERO_MASK | arch_regs_pkg::FLAGS_ONE_MASK);
        load_mask[arch_regs_pkg::VM_BIT] = 1'b0;
        load_mask[arch_regs_pkg::IE_BIT] = 1'b0;
        load_mask[arch_regs_pkg::IO_PRIVILEGE_CEILING_LO +: 2] = 2'h0;
        case (flags_op_i)
            arch_regs_pkg::FOP_POP: begin
                load_mask[arch_regs_pkg::IE_BIT] = within_ceiling;
                load_mask[arch_regs_pkg::IO_PRIVILEGE_CEILING_LO +: 2] = {2{priv_kernel}};
            end
            arch_regs_pkg::FOP_INTERRUPT_RETURN_INSTR: begin
                load_mask[arch_regs_pkg::IE_BIT] = within_ceiling;
                load_mask[arch_regs_pkg::IO_PRIVILEGE_CEILING_LO +: 2] = {2{priv_kernel}};
                load_mask[arch_regs_pkg::VM_BIT] = priv_kernel && protected_mode_i;
            end
            arch_regs_pkg::FOP_TASK: begin
                load_mask[arch_regs_pkg::IE_BIT] = 1'b1;
                load_mask[arch_regs_pkg::IO_PRIVILEGE_CEILING_LO +: 2] = 2'h3;
                load_mask[arch_regs_pkg::VM_BIT] = protected_mode_i;
            end
            default: load_mask = 32'h0000_0000;
        endcase
    end

    wire logic image_op = flags_op_i == arch_regs_pkg::FOP_POP ||
                          flags_op_i == arch_regs_pkg::FOP_INTERRUPT_RETURN_INSTR ||
                          flags_op_i == arch_regs_pkg::FOP_TASK;
    wire logic [31:0] flags_loaded = (flags_w & ~load_mask) | (flags_image_i & load_mask);
    wire logic [31:0] bus_flags = {flags_w[31:16], reg_wdata_i[15:0]};

    always_comb begin
        status_control_word_d = flags_w;
        if (image_op) begin
            status_control_word_d = flags_loaded;
        end else if (flags_op_i == arch_regs_pkg::FOP_RETIRE) begin
            status_control_word_d[arch_regs_pkg::RF_BIT] = 1'b0;
        end else if (bus_flags_wr) begin
            status_control_word_d = reg_wdata_i;
        end else if (bus_short_flags_wr) begin
            status_control_word_d = bus_flags;
        end
        status_control_word_d = (status_control_word_d & ~arch_regs_pkg::FLAGS_ZERO_MASK)
                                | arch_regs_pkg::FLAGS_ONE_MASK;
    end

    // Stored image: reserved bits fixed; emulation bit only for interrupt/task saves
    logic [31:0] store_image;
    always_comb begin
        store_image = (flags_w & ~arch_regs_pkg::FLAGS_ZERO_MASK)
                      | arch_regs_pkg::FLAGS_ONE_MASK;
        store_image[arch_regs_pkg::VM_BIT] = flags_store_i && legacy_emulation_enable;
    end

    // ****************************************
    // Alignment and protection checks
    // ****************************************
    logic misaligned;
    always_comb begin
        case (mem_ref_i.size)
            arch_regs_pkg::SIZE_WORD: misaligned = mem_ref_i.addr[0];
            arch_regs_pkg::SIZE_DWORD: misaligned = |mem_ref_i.addr[1:0];
            arch_regs_pkg::SIZE_QWORD: misaligned = |mem_ref_i.addr[2:0];
            default: misaligned = 1'b0;
        endcase
    end

    // Split halves of an aligned operand come in with split_ok and are exempt
    wire logic align_fault = mem_ref_i.valid && misaligned && alignment_check_enable
                             && current_privilege_i == arch_regs_pkg::PRIV_USER
                             && !mem_ref_i.implicit_kernel
                             && !mem_ref_i.split_ok;
    wire logic emu_active = legacy_emulation_enable && protected_mode_i;
    wire logic gp_fault = privileged_opcode_i && emu_active;
    wire logic io_in_ceiling = !protected_mode_i || within_ceiling;

    arch_regs_pkg::fault_type fault_d;
    always_comb begin
        fault_d = '0;
        if (align_fault) begin
            fault_d.valid = 1'b1;
            fault_d.vector = arch_regs_pkg::ALIGN_VECTOR;
            fault_d.err_code = arch_regs_pkg::ALIGN_ERR_CODE;
        end else if (gp_fault) begin
            fault_d.valid = 1'b1;
            fault_d.vector = arch_regs_pkg::GP_VECTOR;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    wire logic byte_ok_core = gpr_wr_i.index < 3'h4 && !addr_calc_i;
    wire logic [2:0] gpr_rd_idx = gpr_rd_index_i;
    wire logic rd_byte_bad = gpr_rd_view_i[1] == 1'b0 && (gpr_rd_idx >= 3'h4 || addr_calc_i);

    always_ff @(posedge sys_clk_i) begin
        for (int i = 0; i < GPR_COUNT; i++) begin
            if (srst_i) begin
                gpr_q[i] <= 32'h0000_0000;
            end else if (gpr_wr_i.valid && gpr_wr_i.index == 3'(i)) begin
                gpr_q[i] <= merge_view(gpr_q[i], gpr_wr_i.view, gpr_wr_i.data, byte_ok_core);
            end else if (reg_wr_i && bus_gpr_hit && bus_gpr_idx == 3'(i)) begin
                gpr_q[i] <= reg_wdata_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            next_instr_pointer_q <= arch_regs_pkg::IP_RESET;
            status_control_word_q <= arch_regs_pkg::FLAGS_RESET;
        end else begin
            if (ip_load_i) begin
                next_instr_pointer_q <= ip_value_i;
            end
            status_control_word_q <= status_control_word_d;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            reg_rdata_o <= 32'h0000_0000;
            gpr_rdata_o <= 32'h0000_0000;
            flags_store_image_o <= arch_regs_pkg::FLAGS_RESET;
            fault_o <= '0;
            io_bitmap_check_o <= 1'b0;
            debug_fault_taken_o <= 1'b0;
            irq_accept_o <= 1'b0;
            inter_task_return_o <= 1'b0;
            sys_reg_grant_o <= 1'b0;
            legacy_emulation_o <= 1'b0;
        end else begin
            reg_rdata_o <= reg_rd_i ? bus_rdata : 32'h0000_0000;
            gpr_rdata_o <= rd_byte_bad ? 32'h0000_0000
                                       : read_view(gpr_q[gpr_rd_idx], gpr_rd_view_i);
            flags_store_image_o <= store_image;
            fault_o <= fault_d;
            io_bitmap_check_o <= io_instr_i && !io_in_ceiling;
            debug_fault_taken_o <= debug_fault_i && !resume_flag;
            irq_accept_o <= maskable_irq_i && flags_w[arch_regs_pkg::IE_BIT];
            inter_task_return_o <= interrupt_return_instr_i && nested_task_flag;
            sys_reg_grant_o <= sys_reg_access_i && priv_kernel;
            legacy_emulation_o <= emu_active;
        end
    end

endmodule

/* File: core/arch_regs_pkg.sv */
// Package: constants and carriers for the architectural register file
package arch_regs_pkg;

    // ****************************************
    // Register bus offsets (word addresses x4)
    // ****************************************
    localparam logic [7:0] GPR_BASE_OFS = 8'h00;
    localparam logic [7:0] GPR_LAST_OFS = 8'h1C;
    localparam logic [7:0] NEXT_IP_OFS = 8'h20;
    localparam logic [7:0] FLAGS_OFS = 8'h24;
    localparam logic [7:0] STATUS_OFS = 8'h28;
    localparam logic [7:0] SHORT_IP_OFS = 8'h2C;
    localparam logic [7:0] SHORT_FLAGS_OFS = 8'h30;

    // ****************************************
    // Flags field positions and reset
    // ****************************************
    localparam int IE_BIT = 9;
    localparam int IO_PRIVILEGE_CEILING_LO = 12;
    localparam int NT_BIT = 14;
    localparam int RF_BIT = 16;
    localparam int VM_BIT = 17;
    localparam int AC_BIT = 18;
    localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
    localparam logic [31:0] FLAGS_ONE_MASK = 32'h0000_0002;
    localparam logic [31:0] FLAGS_ZERO_MASK = 32'hFFF8_8028;
    localparam logic [31:0] IP_RESET = 32'h0000_FFF0;

    // ****************************************
    // Fault vectors and privilege levels
    // ****************************************
    localparam logic [7:0] ALIGN_VECTOR = 8'h11;
    localparam logic [7:0] GP_VECTOR = 8'h0D;
    localparam logic [31:0] ALIGN_ERR_CODE = 32'h0000_0000;
    localparam logic [1:0] PRIV_KERNEL = 2'h0;
    localparam logic [1:0] PRIV_USER = 2'h3;

    // Register operand width of a general register access
    typedef enum logic [1:0] {
        VIEW_LOW_BYTE = 2'h0,
        VIEW_HIGH_BYTE = 2'h1,
        VIEW_WORD = 2'h3,
        VIEW_DWORD = 2'h2
    } gpr_view_type;

    // Memory operand size for alignment checking
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0,
        SIZE_WORD = 2'h1,
        SIZE_DWORD = 2'h3,
        SIZE_QWORD = 2'h2
    } mem_size_type;

    // Flags-writing operations issued by the core
    typedef enum logic [2:0] {
        FOP_NONE = 3'h0,
        FOP_POP = 3'h1,
        FOP_INTERRUPT_RETURN_INSTR = 3'h3,
        FOP_TASK = 3'h2,
        FOP_RETIRE = 3'h6
    } flags_op_type;

    typedef struct packed {
        logic valid;
        logic [2:0] index;
        gpr_view_type view;
        logic [31:0] data;
    } gpr_write_type;

    typedef struct packed {
        logic valid;
        mem_size_type size;
        logic [31:0] addr;
        logic implicit_kernel;
        logic split_ok;
    } mem_ref_type;

    typedef struct packed {
        logic valid;
        logic [7:0] vector;
        logic [31:0] err_code;
    } fault_type;

endpackage

/* File: testbench/arch_register_file_flags_chk.sv */
// Checker: port-level assertions for the architectural register file
`timescale 1ns/1ps
module arch_register_file_flags_chk (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [1:0] current_privilege_i,
    input wire logic protected_mode_i,
    input wire arch_regs_pkg::mem_ref_type mem_ref_i,
    input wire logic io_instr_i,
    input wire logic privileged_opcode_i,
    input wire logic sys_reg_access_i,
    input wire logic debug_fault_i,
    input wire logic maskable_irq_i,
    input wire logic interrupt_return_instr_i,
    input wire logic [31:0] flags_store_image_o,
    input wire arch_regs_pkg::fault_type fault_o,
    input wire logic io_bitmap_check_o,
    input wire logic debug_fault_taken_o,
    input wire logic irq_accept_o,
    input wire logic inter_task_return_o,
    input wire logic sys_reg_grant_o,
    input wire logic legacy_emulation_o
);
    // ****************
    // Alignment helper
    // ****************
    wire logic [2:0] low_addr = mem_ref_i.addr[2:0];
    wire logic aligned = (mem_ref_i.size == arch_regs_pkg::SIZE_BYTE) || (low_addr == 3'h0)
        || (mem_ref_i.size == arch_regs_pkg::SIZE_WORD && !low_addr[0])
        || (mem_ref_i.size == arch_regs_pkg::SIZE_DWORD && low_addr[1:0] == 2'h0);

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    a_fault_code: assert property (
        fault_o.valid |-> fault_o.err_code == 32'h0 && (fault_o.vector == 8'h11 ||
        fault_o.vector == 8'h0D)) else $error("fault with bad vector or code");
    a_low_level_quiet: assert property (
        mem_ref_i.valid && current_privilege_i != 2'h3 && !privileged_opcode_i
        |=> !fault_o.valid) else $error("alignment fault below level 3");
    a_implicit_quiet: assert property (
        mem_ref_i.implicit_kernel && !privileged_opcode_i |=> !fault_o.valid)
        else $error("alignment fault on implicit kernel access");
    a_aligned_quiet: assert property (
        mem_ref_i.valid && aligned && !privileged_opcode_i |=> !fault_o.valid)
        else $error("alignment fault on aligned access");
    a_store_fixed: assert property (
        (flags_store_image_o & 32'hFFF8_8028) == 32'h0 && flags_store_image_o[1])
        else $error("stored flags image has bad fixed bits");
    a_sysreg_level: assert property (
        sys_reg_access_i |=> sys_reg_grant_o == ($past(current_privilege_i) == 2'h0))
        else $error("system register grant wrong for level");
    a_io_exempt: assert property (
        !io_instr_i || !protected_mode_i || current_privilege_i == 2'h0
        |=> !io_bitmap_check_o) else $error("needless io permission check");
    a_legacy_real: assert property (
        !protected_mode_i |=> !legacy_emulation_o) else $error("emulation outside protected");
    a_irq_gate: assert property (
        !maskable_irq_i |=> !irq_accept_o) else $error("interrupt accepted without request");
    a_debug_gate: assert property (
        !debug_fault_i |=> !debug_fault_taken_o) else $error("debug fault without cause");
    a_return_gate: assert property (
        !interrupt_return_instr_i |=> !inter_task_return_o) else $error("task return without return");

    c_align_fault: cover property (fault_o.valid && fault_o.vector == 8'h11);
    c_irq_taken: cover property (irq_accept_o);
    c_task_return: cover property (inter_task_return_o);
endmodule

bind arch_register_file_flags arch_register_file_flags_chk arch_register_file_flags_chk_inst (.*);

/* File: testbench/tb_arch_register_file_flags.sv */
// Testbench: self-checking run of the architectural register file
`timescale 1ns/1ps
module tb_arch_register_file_flags;
    logic sys_clk_i = 1'h0, srst_i = 1'h1, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
    logic addr_calc_i = 1'h0, ip_load_i = 1'h0, protected_mode_i = 1'h1, flags_store_i = 1'h0;
    logic io_instr_i = 1'h0, privileged_opcode_i = 1'h0, sys_reg_access_i = 1'h0;
    logic debug_fault_i = 1'h0, maskable_irq_i = 1'h0, interrupt_return_instr_i = 1'h0, e;
    logic [7:0] reg_addr_i = 8'h00;
    logic [2:0] gpr_rd_index_i = 3'h0;
    logic [1:0] current_privilege_i = 2'h0;
    logic [31:0] reg_wdata_i = 32'h0, ip_value_i = 32'h0, flags_image_i = 32'h0;
    arch_regs_pkg::gpr_write_type gpr_wr_i = '0;
    arch_regs_pkg::gpr_view_type gpr_rd_view_i = arch_regs_pkg::VIEW_DWORD;
    arch_regs_pkg::flags_op_type flags_op_i = arch_regs_pkg::FOP_NONE;
    arch_regs_pkg::mem_ref_type mem_ref_i = '0;
    arch_regs_pkg::fault_type fault_o;
    logic [31:0] reg_rdata_o, gpr_rdata_o, flags_store_image_o;
    logic io_bitmap_check_o, debug_fault_taken_o, irq_accept_o, inter_task_return_o;
    logic sys_reg_grant_o, legacy_emulation_o;
    int failures = 0, check_count = 0;
    logic [31:0] seed = 32'hC186CBF1, mf = 32'h2, r, d;
    logic [31:0] mg [8];
    logic [2:0] op_codes [4] = '{3'h1, 3'h3, 3'h2, 3'h6};

    arch_register_file_flags arch_register_file_flags_inst (.*);

    always #12.5 sys_clk_i = ~sys_clk_i;

    // **************
    // Model and bus
    // **************
    function automatic logic [31:0] nx();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic [31:0] fx(logic [31:0] v);
        return (v & 32'h0007_7FD7) | 32'h2;
    endfunction
    // Kept bits: ceiling and enable by privilege tests; emulation always on pop, by privilege test on return
    function automatic logic [31:0] fnext(logic [31:0] o, i, logic [2:0] op, logic [1:0] c);
        logic [31:0] k;
        k = 32'h0;
        if (op == 3'h6) return o & 32'hFFFE_FFFF;
        if (op != 3'h2) begin
            k[17] = (op == 3'h1) || (c != 2'h0);
            k[13:12] = {2{c != 2'h0}};
            k[9] = c > o[13:12];
        end
        return fx((o & k) | (i & ~k));
    endfunction
    function automatic logic mis(logic [1:0] s, logic [2:0] o);
        return (s == 2'h1 && o[0]) || (s == 2'h3 && o[1:0] != 2'h0) || (s == 2'h2 && o != 3'h0);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'h1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'h1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'h0;
        #1;
        chk(reg_rdata_o, v);
    endtask
    task automatic core(input logic [2:0] op, input logic [31:0] img, input logic [1:0] c);
        @(posedge sys_clk_i);
        flags_op_i <= arch_regs_pkg::flags_op_type'(op);
        flags_image_i <= img;
        current_privilege_i <= c;
        @(posedge sys_clk_i);
        flags_op_i <= arch_regs_pkg::FOP_NONE;
        mf = fnext(mf, img, op, c);
    endtask
    task automatic levels(input logic [1:0] c, input logic p);
        @(posedge sys_clk_i);
        {io_instr_i, maskable_irq_i, debug_fault_i, interrupt_return_instr_i} <= 4'hF;
        {privileged_opcode_i, sys_reg_access_i, flags_store_i} <= {2'h3, c[1]};
        current_privilege_i <= c;
        protected_mode_i <= p;
        settle();
        e = mf[17] && p;
        chk({irq_accept_o, debug_fault_taken_o}, {mf[9], !mf[16]});
        chk({inter_task_return_o, legacy_emulation_o}, {mf[14], e});
        chk({io_bitmap_check_o, sys_reg_grant_o}, {p && c > mf[13:12], c == 2'h0});
        chk({fault_o.valid, fault_o.vector}, {e, e ? 8'h0D : 8'h00});
        d = c[1] ? 32'hFFFE_FFFF : 32'hFFFC_FFFF;
        chk(flags_store_image_o & 32'hFFFE_FFFF, fx(mf) & d);
    endtask
    task automatic complete_run();
        if (failures == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (10000) @(posedge sys_clk_i);
        failures++;
        complete_run();
    end

    // **************
    // Scenarios
    // **************
    initial begin
        repeat (20) @(posedge sys_clk_i);
        srst_i <= 1'h0;
        rd(8'h24, 32'h2);
        rd(8'hF0, 32'h0);
        rd(8'h20, 32'h0000_FFF0);
        for (int j = 0; j < 8; j++) begin
            mg[j] = nx();
            wr({3'h0, j[2:0], 2'h0}, mg[j]);
        end
        for (int j = 0; j < 16; j++) begin
            r = nx();
            d = {r[31:16], r[7:0], r[7:0]};
            @(posedge sys_clk_i);
            gpr_wr_i <= '{1'h1, j[2:0],
                          j[3] ? arch_regs_pkg::VIEW_HIGH_BYTE : arch_regs_pkg::VIEW_WORD, d};
            if (!j[3]) mg[j[2:0]][15:0] = d[15:0];
            else if (!j[2]) mg[j[2:0]][15:8] = d[7:0];
        end
        @(posedge sys_clk_i);
        gpr_wr_i.valid <= 1'h0;
        for (int j = 0; j < 8; j++) rd({3'h0, j[2:0], 2'h0}, mg[j]);
        for (int j = 0; j < 32; j++) begin
            @(posedge sys_clk_i);
            gpr_rd_index_i <= j[2:0];
            gpr_rd_view_i <= arch_regs_pkg::gpr_view_type'(j[4:3]);
            addr_calc_i <= j[3] & j[1];
            settle();
            r = {24'h0, j[3] ? mg[j[2:0]][15:8] : mg[j[2:0]][7:0]};
            if (j[4]) r = j[3] ? {16'h0, mg[j[2:0]][15:0]} : mg[j[2:0]];
            chk(gpr_rdata_o, (!j[4] && (j[2] || (j[3] && j[1]))) ? 32'h0 : r);
        end
        r = nx();
        @(posedge sys_clk_i);
        {ip_load_i, ip_value_i} <= {1'h1, r};
        @(posedge sys_clk_i);
        ip_load_i <= 1'h0;
        wr(8'h20, ~r);
        rd(8'h20, r);
        rd(8'h2C, {16'h0, r[15:0]});
        wr(8'h24, 32'hFFFF_FFFF);
        mf = fx(32'hFFFF_FFFF);
        rd(8'h24, mf);
        rd(8'h30, {16'h0, mf[15:0]});
        for (int k = 0; k < 24; k++) begin
            r = nx();
            core(op_codes[k % 4], nx(), r[1:0]);
            rd(8'h24, mf);
            rd(8'h28, {27'h0, mf[17:16], mf[14:12]});
        end
        for (int i = 0; i < 256; i++) begin
            if (i[6:0] == 7'h0) wr(8'h24, {13'h0, i[7], 18'h0});
            if (i[6:0] == 7'h0) mf = fx({13'h0, i[7], 18'h0});
            r = nx();
            @(posedge sys_clk_i);
            mem_ref_i <= '{1'h1, arch_regs_pkg::mem_size_type'(i[1:0]), {r[31:3], i[4:2]}, i[6],
                           i[7] & i[3] & i[2]};
            current_privilege_i <= {i[5], 1'h1};
            @(posedge sys_clk_i);
            mem_ref_i.valid <= 1'h0;
            #1;
            e = mf[18] && i[5] && !i[6] && !(i[7] && i[3] && i[2]) && mis(i[1:0], i[4:2]);
            chk({fault_o.valid, fault_o.vector & {8{e}}}, {e, 8'h11 & {8{e}}});
        end
        core(3'h2, 32'h0003_5200, 2'h3);
        levels(2'h3, 1'h1);
        core(3'h6, 32'h0, 2'h0);
        levels(2'h0, 1'h1);
        levels(2'h3, 1'h0);
        complete_run();
    end
endmodule
